/* File: logic/rmii_phy_link_control.v */
// Purpose: rmii mac-side link control, transceiver reset/irq handling, mdio probe
// Assumes: 50 MHz clk; reference clock sampled as ordinary input
// Notes: byte-wide tx/rx through registers; mdio is a simple bit shifter
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`include "rmii_link_consts.vh"

module rmii_phy_link_control #(
    parameter INIT_CYCLES = `INIT_CYCLES,
    parameter RESET_CYCLES = `RESET_CYCLES
) (
    // system
    input wire clk,
    input wire resetn,
    // avalon-mm slave
    input wire [4:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output reg waitrequest,
    output reg irq,
    // rmii data
    input wire ref_clk,
    input wire [1:0] rxd,
    input wire crs_dv,
    output reg tx_en,
    output reg [1:0] txd,
    // management
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe_n,
    output reg mdc,
    // straps and transceiver control
    input wire variant_select,
    input wire fixed_link_n,
    input wire transceiver_irq_n,
    output reg transceiver_reset_n
);

localparam S_INIT = 3'h0;
localparam S_RESET = 3'h1;
localparam S_PROBE = 3'h2;
localparam S_RUN = 3'h3;
localparam S_OFF = 3'h4;

reg rst_a;
reg rst_s;
reg [1:0] ref_sync;
reg [1:0] rxd_s0, rxd_s1;
reg [1:0] crs_s;
reg [1:0] mdin_s;
reg [1:0] var_s;
reg [1:0] fix_s;
reg [1:0] irqn_s;
reg ref_prev;
reg irqn_prev;
reg [2:0] state;
reg [15:0] count;
reg rmii_mode;
reg fixed_mode;
reg phy_found;
reg wired;
reg speed100;
reg duplex;
reg [3:0] ctrl;
reg [`IRQ_W-1:0] irq_stat;
reg [`IRQ_W-1:0] irq_mask;
reg [7:0] tx_byte;
reg [2:0] tx_pairs;
reg tx_busy;
reg [3:0] tx_rep;
reg [7:0] rx_shift;
reg [1:0] rx_pairs;
reg [3:0] rx_rep;
reg [7:0] rx_byte;
reg rx_valid;
reg [31:0] md_shift;
reg [31:0] md_capture;
reg [5:0] md_bits;
reg [4:0] md_div;
reg md_busy;
reg md_done;
reg md_start;
reg ack;

wire ref_rise = ref_sync[1] & ~ref_prev;
wire link_evt = irqn_prev & ~irqn_s[1];
wire access = (read | write) & waitrequest & ~ack;
// register side effects land where the master sees waitrequest low
wire sel_write = write & ~waitrequest;
wire sel_read = read & ~waitrequest;
wire slow_ok = speed100 | (rx_rep == 4'h0);
wire [`IRQ_W-1:0] evt = {md_done, (tx_busy & ref_rise & tx_pairs == 3'h0 & tx_rep == 4'h0),
    (rx_pairs == 2'h3 & ref_rise & crs_s[1] & slow_ok & wired), link_evt};

function is_reg;
    input [4:0] a;
    input [4:0] off;
    begin
        is_reg = (a == off);
    end
endfunction

function [31:0] reg_value;
    input [4:0] a;
    begin
        if (is_reg(a, `REG_CTRL)) begin
            reg_value = {28'h0, ctrl};
        end else if (is_reg(a, `REG_STATUS)) begin
            reg_value = {23'h0, rx_valid, tx_busy, transceiver_reset_n, phy_found,
                duplex, speed100, wired, fixed_mode, rmii_mode};
        end else if (is_reg(a, `REG_IRQ)) begin
            reg_value = {28'h0, irq_stat};
        end else if (is_reg(a, `REG_MASK)) begin
            reg_value = {28'h0, irq_mask};
        end else if (is_reg(a, `REG_RXDATA)) begin
            reg_value = {24'h0, rx_byte};
        end else if (is_reg(a, `REG_MDIO)) begin
            reg_value = md_capture;
        end else begin
            reg_value = 32'h0;
        end
    end
endfunction

// reset release synchroniser
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rst_a <= 1'b0;
        rst_s <= 1'b0;
    end else begin
        rst_a <= 1'b1;
        rst_s <= rst_a;
    end
end

// pin synchronisers; ref clock is sampled, not used as a clock
always @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
        ref_sync <= 2'h0;
        rxd_s0 <= 2'h0;
        rxd_s1 <= 2'h0;
        crs_s <= 2'h0;
        mdin_s <= 2'h3;
        var_s <= 2'h3;
        fix_s <= 2'h3;
        irqn_s <= 2'h3;
        ref_prev <= 1'b0;
        irqn_prev <= 1'b1;
    end else begin
        ref_sync <= {ref_sync[0], ref_clk};
        rxd_s0 <= rxd;
        rxd_s1 <= rxd_s0;
        crs_s <= {crs_s[0], crs_dv};
        mdin_s <= {mdin_s[0], mdio_in};
        var_s <= {var_s[0], variant_select};
        fix_s <= {fix_s[0], fixed_link_n};
        irqn_s <= {irqn_s[0], transceiver_irq_n};
        ref_prev <= ref_sync[1];
        irqn_prev <= irqn_s[1];
    end
end

// bring-up sequence: init, transceiver reset, probe, run
always @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
        state <= S_INIT;
        count <= 16'h0;
        transceiver_reset_n <= 1'b0;
        rmii_mode <= 1'b0;
        fixed_mode <= 1'b0;
        phy_found <= 1'b0;
        wired <= 1'b0;
        speed100 <= 1'b0;
        duplex <= 1'b0;
        md_start <= 1'b0;
    end else begin
        md_start <= 1'b0;
        case (state)
            S_INIT: begin
                count <= count + 16'h1;
                if (count == INIT_CYCLES[15:0]) begin
                    // straps caught after reset release, not at reset
                    rmii_mode <= ~var_s[1];
                    fixed_mode <= ~fix_s[1];
                    count <= 16'h0;
                    state <= S_RESET;
                end
            end
            S_RESET: begin
                transceiver_reset_n <= 1'b0;
                count <= count + 16'h1;
                if (count == RESET_CYCLES[15:0]) begin
                    transceiver_reset_n <= 1'b1;
                    count <= 16'h0;
                    if (fixed_mode) begin
                        speed100 <= 1'b1;
                        duplex <= 1'b1;
                        wired <= 1'b1;
                        state <= S_RUN;
                    end else begin
                        md_start <= 1'b1;
                        state <= S_PROBE;
                    end
                end
            end
            S_PROBE: begin
                if (md_done) begin
                    // an open line reads all ones: no transceiver
                    phy_found <= (md_capture[15:0] != 16'hffff);
                    wired <= (md_capture[15:0] != 16'hffff);
                    speed100 <= md_capture[`ST_SPEED100 - 3];
                    duplex <= md_capture[`ST_DUPLEX - 3];
                    state <= (md_capture[15:0] != 16'hffff) ? S_RUN : S_OFF;
                end
            end
            S_RUN: begin
                if (fixed_mode) begin
                    speed100 <= 1'b1;
                    duplex <= 1'b1;
                end else if (ctrl[`CTRL_ENABLE]) begin
                    speed100 <= ctrl[`CTRL_SPEED100];
                    duplex <= ctrl[`CTRL_DUPLEX];
                end
                if ((link_evt & ~fixed_mode) | ctrl[`CTRL_REINIT]) begin
                    wired <= 1'b0;
                    count <= 16'h0;
                    state <= S_RESET;
                end
            end
            default: begin
                wired <= 1'b0;
            end
        endcase
    end
end

// management shifter: frame in md_shift, mdc derived from clk
always @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
        md_shift <= 32'h0;
        md_capture <= 32'h0;
        md_bits <= 6'h0;
        md_div <= 5'h0;
        md_busy <= 1'b0;
        md_done <= 1'b0;
        mdc <= 1'b0;
        mdio_out <= 1'b1;
        mdio_oe_n <= 1'b1;
    end else begin
        md_done <= 1'b0;
        if (fixed_mode) begin
            mdc <= 1'b0;
            mdio_oe_n <= 1'b1;
            md_busy <= 1'b0;
        end else if (!md_busy) begin
            mdio_oe_n <= 1'b1;
            if (md_start | (sel_write & is_reg(address, `REG_MDIO))) begin
                md_shift <= md_start ? 32'h6002ffff : writedata;
                md_bits <= `MDIO_BITS;
                md_div <= 5'h0;
                md_busy <= 1'b1;
            end
        end else begin
            md_div <= md_div + 5'h1;
            if (md_div == `MDC_HALF) begin
                md_div <= 5'h0;
                mdc <= ~mdc;
                if (!mdc) begin
                    md_capture <= {md_capture[30:0], mdin_s[1]};
                end else begin
                    // low half drives, upper 16 bits only; rest turns over to the phy
                    mdio_out <= md_shift[31];
                    mdio_oe_n <= ~(md_bits > 6'h10);
                    md_shift <= {md_shift[30:0], 1'b1};
                    md_bits <= md_bits - 6'h1;
                    if (md_bits == 6'h0) begin
                        md_busy <= 1'b0;
                        md_done <= 1'b1;
                        mdio_oe_n <= 1'b1;
                    end
                end
            end
        end
    end
end

// rmii transmit and receive on ref clock rising edges
always @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
        tx_en <= 1'b0;
        txd <= 2'h0;
        tx_byte <= 8'h0;
        tx_pairs <= 3'h0;
        tx_rep <= 4'h0;
        tx_busy <= 1'b0;
        rx_shift <= 8'h0;
        rx_pairs <= 2'h0;
        rx_rep <= 4'h0;
        rx_byte <= 8'h0;
        rx_valid <= 1'b0;
    end else begin
        if (sel_write & is_reg(address, `REG_TXDATA) & ~tx_busy & wired) begin
            tx_byte <= writedata[7:0];
            tx_pairs <= 3'h4;
            tx_rep <= 4'h0;
            tx_busy <= 1'b1;
        end else if (ref_rise & tx_busy) begin
            if (tx_rep != 4'h0) begin
                tx_rep <= tx_rep - 4'h1;
            end else if (tx_pairs == 3'h0) begin
                tx_busy <= 1'b0;
                tx_en <= 1'b0;
            end else begin
                tx_en <= 1'b1;
                txd <= tx_byte[1:0];
                tx_byte <= {2'h0, tx_byte[7:2]};
                tx_pairs <= tx_pairs - 3'h1;
                tx_rep <= speed100 ? 4'h0 : `SLOW_REPEAT;
            end
        end
        // read clear first so a byte landing in the same cycle is kept
        if (sel_read & is_reg(address, `REG_RXDATA)) begin
            rx_valid <= 1'b0;
        end
        if (ref_rise & wired) begin
            if (!crs_s[1]) begin
                rx_pairs <= 2'h0;
                rx_rep <= 4'h0;
            end else if (slow_ok) begin
                rx_rep <= speed100 ? 4'h0 : `SLOW_REPEAT;
                rx_shift <= {rxd_s1, rx_shift[7:2]};
                rx_pairs <= rx_pairs + 2'h1;
                if (rx_pairs == 2'h3) begin
                    rx_byte <= {rxd_s1, rx_shift[7:2]};
                    rx_valid <= 1'b1;
                end
            end else begin
                rx_rep <= rx_rep - 4'h1;
            end
        end
    end
end

// avalon slave: one wait state, then answer
always @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
        waitrequest <= 1'b1;
        ack <= 1'b0;
        readdata <= 32'h0;
        ctrl <= 4'h0;
        irq_stat <= {`IRQ_W{1'b0}};
        irq_mask <= {`IRQ_W{1'b0}};
        irq <= 1'b0;
    end else begin
        ack <= access;
        waitrequest <= ~access;
        ctrl[`CTRL_REINIT] <= 1'b0;
        if (access & read) begin
            readdata <= reg_value(address);
        end
        if (sel_write & is_reg(address, `REG_CTRL)) begin
            ctrl <= writedata[3:0];
        end
        if (sel_write & is_reg(address, `REG_MASK)) begin
            irq_mask <= writedata[`IRQ_W-1:0];
        end
        // a new event wins over a write-one clear in the same cycle
        if (sel_write & is_reg(address, `REG_IRQ)) begin
            irq_stat <= (irq_stat & ~writedata[`IRQ_W-1:0]) | evt;
        end else begin
            irq_stat <= irq_stat | evt;
        end
        irq <= |(irq_stat & irq_mask);
    end
end

endmodule // rmii_phy_link_control

/* File: logic/rmii_link_consts.vh */
// Purpose: shared constants for the rmii link control block
// Assumes: 50 MHz system clock
// Notes: register offsets are byte addresses on a 32-bit avalon slave
`ifndef RMII_LINK_CONSTS_VH
`define RMII_LINK_CONSTS_VH
// register byte offsets (word aligned)
`define REG_CTRL 5'h0
`define REG_STATUS 5'h4
`define REG_IRQ 5'h8
`define REG_MASK 5'hc
`define REG_TXDATA 5'h10
`define REG_RXDATA 5'h14
`define REG_MDIO 5'h18
// ctrl fields
`define CTRL_ENABLE 0
`define CTRL_SPEED100 1
`define CTRL_DUPLEX 2
`define CTRL_REINIT 3
// status fields
`define ST_RMII 0
`define ST_FIXED 1
`define ST_WIRED 2
`define ST_SPEED100 3
`define ST_DUPLEX 4
`define ST_PHY_FOUND 5
`define ST_RESET_DONE 6
`define ST_TX_BUSY 7
`define ST_RX_VALID 8
// irq events
`define IRQ_LINK 0
`define IRQ_RX 1
`define IRQ_TX 2
`define IRQ_MDIO 3
`define IRQ_W 4
// timing
`define INIT_TIME_US 10
`define CLK_MHZ 50
`define INIT_CYCLES (`INIT_TIME_US * `CLK_MHZ)
`define RESET_TIME_US 10
`define RESET_CYCLES (`RESET_TIME_US * `CLK_MHZ)
`define SLOW_REPEAT 4'h9
`define MDC_HALF 5'h13
`define MDIO_BITS 6'h20
`endif

/* File: testbench/rmii_far_end.sv */
// Purpose: far-side transceiver model for the rmii link block
// Assumes: free-running reference clock, 160 ns in the bench
// Notes: mdio has a pull-up; a present phy answers low when released
`timescale 1ns/10ps
module rmii_far_end (
    // link
    output reg ref_clk,
    output wire [1:0] rxd,
    output wire crs_dv,
    input wire tx_en,
    input wire [1:0] txd,
    // management and control
    input wire mdio_out,
    input wire mdio_oe_n,
    output wire mdio_in,
    input wire phy_on,
    input wire link_evt,
    output wire transceiver_irq_n,
    // capture
    input wire clr,
    input wire [3:0] rep,
    output reg [7:0] tx_byte,
    output reg [7:0] tx_cnt
);
    initial begin
        ref_clk = 1'b0;
        forever #80 ref_clk = ~ref_clk;
    end
    // transceiver in loopback: what is sent comes back on receive
    assign rxd = txd;
    assign crs_dv = tx_en;
    assign mdio_in = !mdio_oe_n ? mdio_out : !phy_on;
    assign transceiver_irq_n = !link_evt;
    always @(posedge ref_clk or posedge clr) begin
        if (clr) begin
            tx_cnt <= 8'h00;
            tx_byte <= 8'h00;
        end else if (tx_en) begin
            tx_cnt <= tx_cnt + 8'h01;
            // first dibit of each slot, lsb pair ends low
            if (tx_cnt % rep == 8'h00) tx_byte <= {txd, tx_byte[7:2]};
        end
    end
endmodule // rmii_far_end

/* File: testbench/rmii_phy_link_control_monitor.sv */
// Purpose: port-level checks for the rmii link control block
// Assumes: bound to the top module, one clock domain
// Notes: bus, reset release and management timing
`timescale 1ns/10ps
module rmii_link_monitor #(
    parameter INIT_CYCLES = 500,
    parameter RESET_CYCLES = 500
) (
    // system
    input wire clk,
    input wire resetn,
    // bus
    input wire [4:0] address,
    input wire read,
    input wire write,
    input wire [31:0] readdata,
    input wire waitrequest,
    // link and straps
    input wire tx_en,
    input wire mdc,
    input wire mdio_oe_n,
    input wire fixed_link_n,
    input wire transceiver_irq_n,
    input wire transceiver_reset_n
);
    reg [15:0] low_cnt;
    reg booted;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt <= 16'h0000;
            booted <= 1'b0;
        end else begin
            low_cnt <= transceiver_reset_n ? 16'h0000 : low_cnt + 16'h0001;
            booted <= booted | transceiver_reset_n;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    AST_ANSWER: assert property ($rose(read || write) |=> !waitrequest)
        else $error("bus request not answered");
    AST_UNMAPPED: assert property (read && address == 5'h1c && !waitrequest |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_READ_HOLD: assert property (!read |=> $stable(readdata))
        else $error("readdata moved without a read");
    AST_XRST_FIRST: assert property ($rose(transceiver_reset_n) && !booted |->
        low_cnt >= INIT_CYCLES + RESET_CYCLES) else $error("transceiver reset released early");
    AST_XRST_EVENT: assert property (booted && transceiver_reset_n && fixed_link_n &&
        $fell(transceiver_irq_n) |-> ##[1:20] !transceiver_reset_n) else $error("no reinit on link event");
    AST_FIXED_IDLE: assert property (!fixed_link_n |-> !mdc && mdio_oe_n)
        else $error("management active in fixed mode");
    AST_MDC_HALF: assert property ($changed(mdc) |=> $stable(mdc) [*8])
        else $error("mdc half period short");
    AST_TXEN_HOLD: assert property ($rose(tx_en) |-> tx_en [*8])
        else $error("tx_en dropped inside a byte");
endmodule // rmii_link_monitor
bind rmii_phy_link_control rmii_link_monitor #(.INIT_CYCLES(INIT_CYCLES), .RESET_CYCLES(RESET_CYCLES)) u_mon (
    .clk, .resetn, .address, .read, .write, .readdata, .waitrequest, .tx_en, .mdc,
    .mdio_oe_n, .fixed_link_n, .transceiver_irq_n, .transceiver_reset_n);

/* File: testbench/rmii_phy_link_control_test.sv */
// Purpose: self-checking bench for the rmii link control block
// Assumes: short init and reset counts of 8 cycles
// Notes: registers reached over avalon, far side is rmii_far_end
`timescale 1ns/10ps
`include "rmii_link_consts.vh"
module rmii_phy_link_control_test;
    localparam INIT = 8;
    localparam RST = 8;
    reg clk, resetn, read, write, variant_select, fixed_link_n, phy_on, link_evt, clr;
    reg [4:0] address;
    reg [31:0] writedata, rd;
    reg [3:0] rep;
    wire [31:0] readdata;
    wire waitrequest, irq, ref_clk, crs_dv, tx_en, mdio_in, mdio_out, mdio_oe_n, mdc;
    wire transceiver_irq_n, transceiver_reset_n;
    wire [1:0] rxd, txd;
    wire [7:0] tx_byte, tx_cnt;
    integer fails, checks_done, cyc;
    rmii_phy_link_control #(.INIT_CYCLES(INIT), .RESET_CYCLES(RST)) u_dut (.clk, .resetn, .address,
        .read, .write, .writedata, .readdata, .waitrequest, .irq, .ref_clk, .rxd, .crs_dv, .tx_en, .txd,
        .mdio_in, .mdio_out, .mdio_oe_n, .mdc, .variant_select, .fixed_link_n, .transceiver_irq_n,
        .transceiver_reset_n);
    rmii_far_end u_far (.ref_clk, .rxd, .crs_dv, .tx_en, .txd, .mdio_out, .mdio_oe_n, .mdio_in,
        .phy_on, .link_evt, .transceiver_irq_n, .clr, .rep, .tx_byte, .tx_cnt);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            fails = fails + 1;
            final_report;
        end
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task bus(input wr, input [4:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            address <= a;
            writedata <= d;
            read <= !wr;
            write <= wr;
            n = 0;
            @(posedge clk);
            while (waitrequest !== 1'b0 && n < 50) begin
                @(posedge clk);
                n = n + 1;
            end
            check(n < 50, 1);
            rd = readdata;
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask
    task wait_irq(input integer b, input e);
        integer n;
        begin
            n = 0;
            rd = 0;
            while (rd[b] !== 1'b1 && n < 1000) begin
                bus(0, `REG_IRQ, 0);
                n = n + 1;
            end
            check(rd[b], e);
        end
    endtask
    task boot(input vs, input fx, input ph);
        integer n;
        begin
            @(posedge clk);
            resetn <= 1'b0;
            variant_select <= vs;
            fixed_link_n <= fx;
            phy_on <= ph;
            repeat (12) @(posedge clk);
            resetn <= 1'b1;
            n = 0;
            while (transceiver_reset_n !== 1'b1 && n < 400) begin
                @(posedge clk);
                n = n + 1;
            end
            check(n >= INIT + RST && n < 400, 1);
            // probe finishes with the mdio done event
            if (fx) wait_irq(`IRQ_MDIO, 1'b1);
        end
    endtask
    task t_phy;
        begin
            boot(1'b0, 1'b1, 1'b1);
            bus(0, `REG_STATUS, 0);
            check(rd[8:0], 9'h065);
            bus(0, `REG_MDIO, 0);
            check(rd, 32'h60020000);
            bus(1, 5'h1c, 32'hffffffff);
            bus(0, 5'h1c, 0);
            check(rd, 0);
        end
    endtask
    task t_tx(input [3:0] r, input [7:0] b);
        begin
            rep <= r;
            clr <= 1'b1;
            bus(1, `REG_IRQ, 32'hf);
            clr <= 1'b0;
            bus(1, 5'h10, b);
            wait_irq(`IRQ_TX, 1'b1);
            check(tx_byte, b);
            check(tx_cnt, {r, 2'b00});
            check({irq, rd[`IRQ_TX]}, 2'b01);
            check(rd[`IRQ_RX], 1'b1);
            bus(0, `REG_RXDATA, 0);
            check(rd[7:0], b);
            bus(0, `REG_STATUS, 0);
            check(rd[8:7], 2'b00);
            bus(1, `REG_MASK, 32'h4);
            bus(0, `REG_MASK, 0);
            check({irq, rd[3:0]}, 5'h14);
            bus(1, `REG_IRQ, 32'h4);
            bus(0, `REG_IRQ, 0);
            check({irq, rd[`IRQ_TX]}, 2'b00);
            bus(1, `REG_MASK, 0);
        end
    endtask
    task t_link;
        integer n;
        begin
            bus(1, `REG_IRQ, 32'hf);
            link_evt <= 1'b1;
            n = 0;
            while (transceiver_reset_n !== 1'b0 && n < 40) begin
                @(posedge clk);
                n = n + 1;
            end
            link_evt <= 1'b0;
            check(n < 40, 1);
            wait_irq(`IRQ_MDIO, 1'b1);
            check({transceiver_reset_n, rd[`IRQ_LINK]}, 2'b11);
            bus(1, `REG_IRQ, 32'hf);
            bus(1, `REG_CTRL, 32'hf);
            wait_irq(`IRQ_MDIO, 1'b1);
            bus(0, `REG_STATUS, 0);
            check(rd[5:3], 3'h7);
            bus(0, `REG_CTRL, 0);
            check(rd[3:0], 4'h7);
        end
    endtask
    task t_nophy;
        begin
            boot(1'b1, 1'b1, 1'b0);
            bus(0, `REG_STATUS, 0);
            check({rd[5], rd[2:0]}, 4'h0);
            clr <= 1'b1;
            bus(1, 5'h10, 32'h5a);
            clr <= 1'b0;
            wait_irq(`IRQ_TX, 1'b0);
            check({tx_cnt, rd[`IRQ_TX]}, 9'h000);
        end
    endtask
    task t_fixed;
        begin
            boot(1'b0, 1'b0, 1'b1);
            bus(0, `REG_STATUS, 0);
            check(rd[4:0], 5'h1f);
            t_tx(4'h1, 8'h3c);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    initial begin
        {resetn, read, write, link_evt, address, writedata, rd} = 0;
        {variant_select, fixed_link_n, phy_on, clr} = 4'hf;
        rep = 4'h1;
        {fails, checks_done, cyc} = 0;
        t_phy;
        t_tx(4'ha, 8'hb4);
        t_link;
        t_nophy;
        t_fixed;
        final_report;
    end
endmodule // rmii_phy_link_control_test
